//--- hw/pan_status_regs.sv
`timescale 1ns/10ps
// Status and auto-negotiation register bank of the PCS host bus
module pan_status_regs
    import pan_pkg::*;
#(
    parameter logic UNIDIR_ABLE = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Host bus
    input wire logic [4:0] host_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // Mode and control
    input wire pan_pkg::pan_mode_type pcs_mode,
    input wire logic autoneg_enable,
    input wire logic [1:0] ctrl_speed,
    // Negotiation state
    input wire logic link_up,
    input wire logic autoneg_done,
    input wire logic page_received,
    input wire logic [15:0] partner_page,
    // Resulting data rate
    output logic [1:0] mii_speed
);
    import pan_pkg::*;

    logic link_latch_n;
    logic page_flag;
    logic [7:0] local_high;
    logic [7:0] local_low;
    logic [7:0] next_local_high;
    logic [7:0] next_local_low;
    logic [7:0] next_rdata;
    logic [7:0] status_low;
    logic [7:0] adv_high;
    logic [7:0] adv_low;
    logic [7:0] lp_high;
    logic [7:0] lp_low;
    logic [1:0] next_speed;
    logic is_sgmii;
    logic rd_status;
    logic rd_expand;

    assign is_sgmii = (pcs_mode != PAN_MODE_GBE);
    assign rd_status = host_rd && (host_addr == OFS_STATUS_LOW);
    assign rd_expand = host_rd && (host_addr == OFS_EXPAND_LOW);

    // Link down latch: flag holds the "link lost" event
    pan_read_flag #(
        .RESET_VALUE(1'b1)
    ) u_link_lost (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(!link_up),
        .clear(rd_status),
        .flag(link_latch_n)
    );

    pan_read_flag #(
        .RESET_VALUE(1'b0)
    ) u_page_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set(page_received),
        .clear(rd_expand),
        .flag(page_flag)
    );

    // Status low image
    always_comb begin
        status_low = STATUS_LOW_FIXED;
        status_low[BIT_UNIDIR] = UNIDIR_ABLE;
        status_low[BIT_AN_DONE] = autoneg_done;
        // Live link gates the latch so a loss reads low at once
        status_low[BIT_LINK] = link_up && !link_latch_n;
    end

    // Advertised ability images per mode
    always_comb begin
        case (pcs_mode)
            PAN_MODE_GBE: begin
                adv_high = local_high & GBE_HIGH_MASK;
                adv_low = local_low & GBE_LOW_MASK;
            end
            PAN_MODE_PHY: begin
                adv_high = local_high & PHY_HIGH_MASK;
                adv_low = SGMII_LOW;
            end
            default: begin
                adv_high = MAC_SIDE_HIGH;
                adv_low = SGMII_LOW;
            end
        endcase
    end

    // Partner ability images per mode
    always_comb begin
        if (is_sgmii) begin
            lp_high = partner_page[15:8] & PHY_HIGH_MASK;
            lp_low = SGMII_LOW;
        end else begin
            lp_high = partner_page[15:8] & GBE_HIGH_MASK;
            lp_low = partner_page[7:0] & GBE_LOW_MASK;
        end
    end

    // Writes to the advertised ability bytes
    always_comb begin
        next_local_high = local_high;
        next_local_low = local_low;
        if (host_wr && pcs_mode == PAN_MODE_GBE) begin
            if (host_addr == OFS_LOCAL_HIGH) begin
                next_local_high = host_wdata & GBE_HIGH_MASK;
            end else if (host_addr == OFS_LOCAL_LOW) begin
                next_local_low = host_wdata & GBE_LOW_MASK;
            end
        end else if (host_wr && pcs_mode == PAN_MODE_PHY) begin
            if (host_addr == OFS_LOCAL_HIGH) begin
                next_local_high = host_wdata & PHY_HIGH_MASK;
            end
        end
    end

    // Read data decode
    always_comb begin
        next_rdata = host_rdata;
        if (host_rd) begin
            if (host_addr == OFS_STATUS_LOW) begin
                next_rdata = status_low;
            end else if (host_addr == OFS_STATUS_HIGH) begin
                next_rdata = STATUS_HIGH_VALUE;
            end else if (host_addr == OFS_LOCAL_LOW) begin
                next_rdata = adv_low;
            end else if (host_addr == OFS_LOCAL_HIGH) begin
                next_rdata = adv_high;
            end else if (host_addr == OFS_PARTNER_LOW) begin
                next_rdata = lp_low;
            end else if (host_addr == OFS_PARTNER_HIGH) begin
                next_rdata = lp_high;
            end else if (host_addr == OFS_EXPAND_LOW) begin
                next_rdata = RESERVED_VALUE;
                next_rdata[BIT_PAGE_RX] = page_flag;
            end else if (host_addr == OFS_EXPAND_HIGH) begin
                next_rdata = RESERVED_VALUE;
            end else if (host_addr == OFS_EXT_HIGH) begin
                next_rdata = EXT_HIGH_VALUE;
            end else if (host_addr == OFS_EXT_LOW) begin
                next_rdata = RESERVED_VALUE;
            end else begin
                next_rdata = RESERVED_VALUE;
            end
        end
    end

    // Data rate: advertised speed field in SGMII with autoneg
    always_comb begin
        if (is_sgmii && autoneg_enable) begin
            next_speed = adv_high[SPEED_LSB +: 2];
        end else begin
            next_speed = ctrl_speed;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            local_high <= LOCAL_HIGH_RESET;
            local_low <= LOCAL_LOW_RESET;
            host_rdata <= RESERVED_VALUE;
            mii_speed <= 2'h0;
        end else begin
            local_high <= next_local_high;
            local_low <= next_local_low;
            host_rdata <= next_rdata;
            mii_speed <= next_speed;
        end
    end
endmodule

//--- hw/pan_pkg.sv
// Register map, field layout and fixed values of the status bank
package pan_pkg;
    // Register offsets on the host bus
    localparam logic [4:0] OFS_STATUS_LOW = 5'h02;
    localparam logic [4:0] OFS_STATUS_HIGH = 5'h03;
    localparam logic [4:0] OFS_LOCAL_LOW = 5'h08;
    localparam logic [4:0] OFS_LOCAL_HIGH = 5'h09;
    localparam logic [4:0] OFS_PARTNER_LOW = 5'h0A;
    localparam logic [4:0] OFS_PARTNER_HIGH = 5'h0B;
    localparam logic [4:0] OFS_EXPAND_LOW = 5'h0C;
    localparam logic [4:0] OFS_EXPAND_HIGH = 5'h0D;
    localparam logic [4:0] OFS_EXT_LOW = 5'h1E;
    localparam logic [4:0] OFS_EXT_HIGH = 5'h1F;

    // Fixed register images
    localparam logic [7:0] STATUS_HIGH_VALUE = 8'h01;
    localparam logic [7:0] STATUS_LOW_FIXED = 8'h08;
    localparam logic [7:0] EXT_HIGH_VALUE = 8'h80;
    localparam logic [7:0] RESERVED_VALUE = 8'h00;
    localparam logic [7:0] MAC_SIDE_HIGH = 8'h40;
    localparam logic [7:0] SGMII_LOW = 8'h01;

    // Writable masks per mode
    localparam logic [7:0] GBE_HIGH_MASK = 8'hF3;
    localparam logic [7:0] GBE_LOW_MASK = 8'hC0;
    localparam logic [7:0] PHY_HIGH_MASK = 8'hDC;

    // Field positions
    localparam int BIT_UNIDIR = 7;
    localparam int BIT_AN_DONE = 5;
    localparam int BIT_LINK = 2;
    localparam int BIT_PAGE_RX = 1;
    localparam int SPEED_LSB = 2;

    // Reset values of writable abilities
    localparam logic [7:0] LOCAL_HIGH_RESET = 8'h00;
    localparam logic [7:0] LOCAL_LOW_RESET = 8'h60;

    typedef enum logic [1:0] {
        PAN_MODE_GBE = 2'b00,
        PAN_MODE_PHY = 2'b01,
        PAN_MODE_MAC = 2'b10
    } pan_mode_type;
endpackage

//--- hw/pan_read_flag.sv
`timescale 1ns/10ps
// Sticky flag that hardware sets and a register read clears
module pan_read_flag #(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic set,
    input wire logic clear,
    // State
    output logic flag
);
    logic next_flag;

    // Set wins over a clear in the same cycle
    always_comb begin
        next_flag = flag;
        if (set) begin
            next_flag = 1'b1;
        end else if (clear) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag <= RESET_VALUE;
        end else begin
            flag <= next_flag;
        end
    end
endmodule

//--- verification/pan_status_regs_checker.sv
// Concurrent checks of the status register bank
`timescale 1ns/10ps
module pan_status_regs_checker
    import pan_pkg::*;
#(
    parameter logic UNIDIR_ABLE = 1'h0
) (
    // Watched ports
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [4:0] host_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire pan_pkg::pan_mode_type pcs_mode,
    input wire logic autoneg_enable,
    input wire logic [1:0] ctrl_speed,
    input wire logic link_up,
    input wire logic autoneg_done,
    input wire logic page_received,
    input wire logic [15:0] partner_page,
    input wire logic [1:0] mii_speed
);
    logic [4:0] ra;
    assign ra = host_rd ? host_addr : 5'h00;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    stat_high_a: assert property (ra == OFS_STATUS_HIGH
        |=> host_rdata == STATUS_HIGH_VALUE) else $error("status high");
    stat_fixed_a: assert property (ra == OFS_STATUS_LOW
        |=> (host_rdata & 8'hDB) == {UNIDIR_ABLE, 7'h08}) else $error("fixed");
    link_latch_a: assert property (ra == OFS_STATUS_LOW && !link_up
        |=> !host_rdata[BIT_LINK]) else $error("link bit");
    an_done_a: assert property (ra == OFS_STATUS_LOW
        |=> host_rdata[BIT_AN_DONE] == $past(autoneg_done)) else $error("done");
    exp_low_a: assert property (ra == OFS_EXPAND_LOW
        |=> (host_rdata & 8'hFD) == 8'h00) else $error("expansion low");
    exp_high_a: assert property (ra == OFS_EXPAND_HIGH
        |=> host_rdata == RESERVED_VALUE) else $error("expansion high");
    mac_fixed_a: assert property (ra == OFS_LOCAL_HIGH
        && pcs_mode == PAN_MODE_MAC
        |=> host_rdata == MAC_SIDE_HIGH) else $error("mac advert");
    sgmii_low_a: assert property (ra == OFS_PARTNER_LOW
        && pcs_mode != PAN_MODE_GBE
        |=> host_rdata == SGMII_LOW) else $error("partner low");
    rate_ctrl_a: assert property (!(autoneg_enable && pcs_mode != PAN_MODE_GBE)
        |=> mii_speed == $past(ctrl_speed)) else $error("rate select");
    cover property (ra == OFS_STATUS_LOW && !link_up);
    cover property (host_wr && pcs_mode == PAN_MODE_PHY);
    cover property (page_received ##[1:4] ra == OFS_EXPAND_LOW);
endmodule

//--- verification/pan_status_regs_tb.sv
// Self-checking bench for the status register bank
`timescale 1ns/10ps
module pan_status_regs_tb;
    import pan_pkg::*;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic [4:0] host_addr = 5'h00;
    logic host_rd = 1'h0;
    logic host_wr = 1'h0;
    logic [7:0] host_wdata = 8'h00;
    logic [7:0] host_rdata;
    pan_mode_type pcs_mode = PAN_MODE_GBE;
    logic autoneg_enable = 1'h0;
    logic [1:0] ctrl_speed = 2'h0;
    logic link_up = 1'h0;
    logic autoneg_done = 1'h0;
    logic page_received = 1'h0;
    logic [15:0] partner_page = 16'h0000;
    logic [1:0] mii_speed;
    logic [31:0] d = 32'h6637;
    logic [1:0] m;
    logic [7:0] hi;
    logic [7:0] exp_q[$];
    logic took = 1'h0;
    int err_count = 0;
    int num_checks = 0;
    pan_status_regs DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
        .host_wdata(host_wdata), .host_rdata(host_rdata),
        .pcs_mode(pcs_mode), .autoneg_enable(autoneg_enable),
        .ctrl_speed(ctrl_speed), .link_up(link_up),
        .autoneg_done(autoneg_done), .page_received(page_received),
        .partner_page(partner_page), .mii_speed(mii_speed));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        num_checks++;
        if (got !== e) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One host access; a read queues its expected value
    task automatic acc(input logic w, input logic [4:0] a,
        input logic [7:0] v);
        @(negedge clk_sys);
        host_addr = a;
        host_wdata = v;
        host_wr = w;
        host_rd = !w;
        if (!w)
            exp_q.push_back(v);
        @(negedge clk_sys);
        host_wr = 1'h0;
        host_rd = 1'h0;
    endtask
    always @(posedge clk_sys)
        took <= host_rd;
    always @(negedge clk_sys)
        if (took)
            chk(host_rdata, exp_q.pop_front());
    initial forever #4 clk_sys = !clk_sys;
    initial begin
        #200000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'h1;
        acc(1'h0, OFS_STATUS_LOW, 8'h08);
        link_up = 1'h1;
        acc(1'h0, OFS_STATUS_LOW, 8'h08);
        acc(1'h0, OFS_STATUS_LOW, 8'h0C);
        autoneg_done = 1'h1;
        acc(1'h0, OFS_STATUS_LOW, 8'h2C);
        link_up = 1'h0;
        @(negedge clk_sys);
        link_up = 1'h1;
        acc(1'h0, OFS_STATUS_LOW, 8'h28);
        acc(1'h0, OFS_STATUS_LOW, 8'h2C);
        acc(1'h1, OFS_STATUS_HIGH, 8'hFE);
        acc(1'h0, OFS_STATUS_HIGH, 8'h01);
        acc(1'h0, OFS_EXPAND_HIGH, 8'h00);
        acc(1'h0, OFS_EXT_HIGH, 8'h80);
        acc(1'h0, OFS_EXT_LOW, 8'h00);
        acc(1'h0, 5'h10, 8'h00);
        acc(1'h0, OFS_EXPAND_LOW, 8'h00);
        page_received = 1'h1;
        @(negedge clk_sys);
        page_received = 1'h0;
        acc(1'h0, OFS_EXPAND_LOW, 8'h02);
        acc(1'h0, OFS_EXPAND_LOW, 8'h00);
        autoneg_enable = 1'h1;
        for (int i = 0; i < 6; i++) begin
            d = lfsr(d);
            m = 2'(i % 3);
            pcs_mode = pan_mode_type'(m);
            partner_page = d[15:0];
            ctrl_speed = d[1:0];
            hi = d[23:16] & (m == 2'h0 ? 8'hF3 : 8'hDC);
            acc(1'h1, OFS_LOCAL_HIGH, d[23:16]);
            acc(1'h1, OFS_LOCAL_LOW, d[31:24]);
            acc(1'h0, OFS_LOCAL_HIGH, m == 2'h2 ? MAC_SIDE_HIGH : hi);
            acc(1'h0, OFS_LOCAL_LOW, m ? SGMII_LOW : d[31:24] & 8'hC0);
            acc(1'h0, OFS_PARTNER_HIGH, d[15:8] & (m ? 8'hDC : 8'hF3));
            acc(1'h0, OFS_PARTNER_LOW, m ? SGMII_LOW : d[7:0] & 8'hC0);
            chk({6'h00, mii_speed}, {6'h00, m == 2'h2 ? 2'h0 :
                (m ? d[19:18] : d[1:0])});
        end
        repeat (2) @(negedge clk_sys);
        summarize();
    end
endmodule
bind pan_status_regs pan_status_regs_checker #(.UNIDIR_ABLE(UNIDIR_ABLE))
    chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .host_addr(host_addr),
    .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .pcs_mode(pcs_mode),
    .autoneg_enable(autoneg_enable), .ctrl_speed(ctrl_speed),
    .link_up(link_up), .autoneg_done(autoneg_done),
    .page_received(page_received), .partner_page(partner_page),
    .mii_speed(mii_speed));
